// *** design/usb_device_control_regs.sv ***
/*
 usb_device_control_regs: control, status, addressing, completion queue
 pointers and interrupt gating of a full/low speed usb device, with an
 ahb-lite register slave. assumes a serial engine that reports tokens,
 sof, completed transactions and line states synchronous to hclk.
*/
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// - enable activates interface, clearing aborts one cycle later
// - speed bit zero low, one full
// - queue enable records completed endpoint table addresses
// - store sof frame number when enabled
// - discard packets above highest endpoint number
// - fetch table entry for allowed endpoints
// - only the d- pull-up held in reset, speed resets low, power-on clears
// - remote wake drives resume after 5ms idle
// - global nack, no memory access except setup
// - attach switches speed-matched pull-up
// - status shows upstream and downstream resume
// - suspended after 3ms idle
// - bus reset after 2.5us se0
// - respond only to own seven-bit address
// - pointer write clears transaction complete flag
// - read pointer reads clear flag when drained
// - five-bit pointers, write flushes both
// - table base 16 bits, bit zero zero
// - unimplemented table base bits read zero
// - sof interrupt gated by enable and level
// - bus event interrupts gated by enable, level
// - level field gates all interrupts
// - pointers decrement, negative offsets, wrap at size
module usb_device_control_regs
	import usb_ctrl_pkg::*;
#(
	parameter int SUSPEND_N = SUSPEND_CYC, // idle cycles to suspend
	parameter int WAKE_N = WAKE_CYC, // idle cycles before wake
	parameter int RESUME_N = RESUME_CYC // upstream resume length
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic por_n, // power-on reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write access
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // always ready
	output logic hresp, // always okay
	input wire pkt_t pkt, // incoming token
	input wire logic sof_valid, // sof token strobe
	input wire logic [10:0] sof_frame, // sof frame number
	input wire logic trn_done, // transaction completed
	input wire logic [15:0] trn_ep_addr, // its table address
	input wire logic line_idle, // bus in idle state
	input wire logic line_se0, // bus in se0
	output fetch_t fetch, // endpoint table fetch
	output logic pkt_nack, // answer nack
	output logic usb_enabled, // interface on
	output logic full_speed, // speed select
	output logic transaction_abort, // abort pulse
	output logic dp_pullup, // d+ pull-up on
	output logic dm_pullup, // d- pull-up on
	output logic resume_drive, // drive upstream resume
	output logic queue_wr_en, // queue memory write
	output logic [15:0] queue_wr_addr, // queue entry address
	output logic [15:0] queue_wr_data, // stored table address
	output logic transaction_complete_flag, // queue pending
	output logic [1:0] irq_priority_level, // interrupt level
	output logic bus_event_irq // bus event request
);
	// next pointer value, wrapping at the queue size
	function automatic logic [4:0] q_dec(input logic [4:0] p, input logic [3:0] mx);
		logic [4:0] n;
		logic [5:0] ent;
		n = p - 5'h01;
		ent = {1'b0, mx, 1'b0} + 6'h02;
		if (n == 5'(6'h00 - ent)) begin
			n = 5'h00;
		end
		return n;
	endfunction

	logic [7:0] main_ctrl; // enable, speed, queue, store, highest ep
	logic pullup_hold_in_reset; // survives non power-on reset
	logic remote_wake_request; // wake request bit
	logic global_negative_ack; // nack every allowed token
	logic attach; // attach bit
	logic [6:0] dev_addr; // own usb address
	logic [15:0] endpoint_table_base; // table base pointer
	logic frame_start_irq_enable; // sof enable
	logic bus_event_irq_enable; // suspend/resume/reset enable
	logic [10:0] last_frame_number; // stored frame
	logic [4:0] queue_write_pointer; // two's complement negative offsets
	logic [4:0] queue_read_pointer;
	logic frame_start_flag, bus_idle_flag, wake_detect_flag, bus_reset_flag;
	logic suspended, upstream_resume_flag, resume_seen, bus_reset_seen;
	logic [19:0] idle_cnt; // idle time counter
	logic [19:0] drive_cnt; // resume drive counter
	logic [8:0] se0_cnt; // se0 time counter
	logic attach_kept; // attach state caught before reset
	logic enable_d; // enable one cycle ago
	logic wr_pend; // write data phase pending
	logic [3:0] wr_idx; // its register index
	logic [3:0] a_idx; // address phase index
	logic a_valid, a_map, a_rd, rp_read;
	logic wr_main, wr_line, wr_ptr, wr_flags;
	logic push, match, allowed;
	logic [3:0] highest_endpoint_number;
	logic [7:0] rd_val;

	assign highest_endpoint_number = main_ctrl[3:0];
	assign usb_enabled = main_ctrl[B_ENABLE];
	assign full_speed = main_ctrl[B_SPEED];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	logic [1:0] main_irq_level; // interrupt level field
	assign irq_priority_level = main_irq_level;

	// address phase decode, only indices up to IDX_FLAGS in the low 64 bytes are mapped, byte lanes ignored
	assign a_valid = hsel & hready & htrans[1];
	assign a_idx = haddr[5:2];
	assign a_map = (haddr[31:6] == 26'h0) & (a_idx <= IDX_FLAGS);
	assign a_rd = a_valid & ~hwrite;
	// read pointer reads pop the queue only while it is enabled
	assign rp_read = a_rd & a_map & (a_idx == IDX_QRP) & main_ctrl[B_QEN];
	assign wr_main = wr_pend & (wr_idx == IDX_MAIN);
	assign wr_line = wr_pend & (wr_idx == IDX_LINE);
	assign wr_ptr = wr_pend & ((wr_idx == IDX_QWP) | (wr_idx == IDX_QRP));
	assign wr_flags = wr_pend & (wr_idx == IDX_FLAGS);
	assign push = trn_done & usb_enabled & main_ctrl[B_QEN];

	// read mux, reserved bits zero
	always_comb begin
		rd_val = 8'h00;
		case (a_idx)
			IDX_MAIN: rd_val = main_ctrl;
			IDX_LINE: rd_val = {3'h0, pullup_hold_in_reset, 1'b0,
				remote_wake_request, global_negative_ack, attach};
			IDX_STATE: rd_val = {4'h0, upstream_resume_flag, resume_seen,
				suspended, bus_reset_seen};
			IDX_ADDR: rd_val = {1'b0, dev_addr};
			IDX_QWP: rd_val = {3'h0, queue_write_pointer};
			IDX_QRP: rd_val = {3'h0, queue_read_pointer};
			IDX_EPL: rd_val = endpoint_table_base[7:0];
			IDX_EPH: rd_val = endpoint_table_base[15:8];
			IDX_IRQEN: rd_val = {frame_start_irq_enable, bus_event_irq_enable,
				4'h0, main_irq_level};
			IDX_FRAME: rd_val = last_frame_number[7:0];
			IDX_FLAGS: rd_val = {frame_start_flag, bus_idle_flag, wake_detect_flag,
				bus_reset_flag, 2'h0, transaction_complete_flag, 1'b0};
			default: rd_val = 8'h00;
		endcase
		if (!a_map) begin
			rd_val = 8'h00; // unmapped reads zero
		end
	end

	// bus slave: capture address phase, read data ready in data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_idx <= 4'h0;
			hrdata <= 32'h0;
		end else begin
			wr_pend <= a_valid & hwrite & a_map;
			wr_idx <= a_idx;
			if (a_rd) begin
				hrdata <= {24'h0, rd_val};
			end
		end
	end

	// software control bits, written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			main_ctrl <= RST_REG;
			global_negative_ack <= 1'b0;
			attach <= 1'b0;
			dev_addr <= 7'h0;
			endpoint_table_base <= 16'h0;
			frame_start_irq_enable <= 1'b0;
			bus_event_irq_enable <= 1'b0;
			main_irq_level <= 2'h0;
		end else if (wr_pend) begin
			case (wr_idx)
				IDX_MAIN: main_ctrl <= hwdata[7:0];
				IDX_LINE: begin
					global_negative_ack <= hwdata[B_GLOBAL_NEGATIVE_ACK];
					attach <= hwdata[B_ATTACH];
				end
				IDX_ADDR: dev_addr <= hwdata[6:0];
				// bit zero and missing bits never store
				IDX_EPL: endpoint_table_base[7:0] <= hwdata[7:0] & EPTR_IMPL_MASK[7:0];
				IDX_EPH: endpoint_table_base[15:8] <= hwdata[7:0] & EPTR_IMPL_MASK[15:8];
				IDX_IRQEN: begin
					frame_start_irq_enable <= hwdata[B_FRAME_START_IRQ_ENABLE];
					bus_event_irq_enable <= hwdata[B_BUS_EVENT_IRQ_ENABLE];
					main_irq_level <= hwdata[1:0];
				end
				default: ;
			endcase
		end
	end

	// hold bit and pre-reset attach state, cleared only by power-on
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			pullup_hold_in_reset <= 1'b0;
			attach_kept <= 1'b0;
		end else if (hresetn) begin
			attach_kept <= attach;
			if (wr_line) begin
				pullup_hold_in_reset <= hwdata[B_HOLD];
			end
		end
	end

	// pull-ups; during reset the kept attach state drives d- only, as speed resets low
	always_comb begin
		dp_pullup = attach & full_speed;
		dm_pullup = attach & ~full_speed;
		if (!hresetn && pullup_hold_in_reset) begin
			dp_pullup = attach_kept & full_speed;
			dm_pullup = attach_kept & ~full_speed;
		end
	end

	// abort pulse on the enable's falling edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_d <= 1'b0;
			transaction_abort <= 1'b0;
		end else begin
			enable_d <= usb_enabled;
			transaction_abort <= enable_d & ~usb_enabled;
		end
	end

	// token handling: address filter, endpoint limit, nack
	assign match = pkt.valid & usb_enabled & (pkt.addr == dev_addr);
	assign allowed = match & (pkt.ep <= highest_endpoint_number);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fetch <= '0;
			pkt_nack <= 1'b0;
		end else begin
			pkt_nack <= allowed & global_negative_ack;
			// under global nack only setup may touch memory
			fetch.req <= allowed & (~global_negative_ack | pkt.setup);
			fetch.addr <= endpoint_table_base + {8'h0, pkt.ep, 4'h0}
				+ (pkt.dir_in ? 16'h0008 : 16'h0000);
		end
	end

	// frame number store
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_frame_number <= 11'h0;
		end else if (sof_valid & usb_enabled & main_ctrl[B_FSTORE]) begin
			last_frame_number <= sof_frame;
		end
	end

	// completion queue pointers; disabling frees and zeroes them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			queue_write_pointer <= 5'h0;
			queue_read_pointer <= 5'h0;
		end else if (!main_ctrl[B_QEN] || wr_ptr) begin
			queue_write_pointer <= 5'h0;
			queue_read_pointer <= 5'h0;
		end else begin
			if (push) begin
				queue_write_pointer <= q_dec(queue_write_pointer, highest_endpoint_number);
			end
			if (rp_read && queue_read_pointer != queue_write_pointer) begin
				queue_read_pointer <= q_dec(queue_read_pointer, highest_endpoint_number);
			end
		end
	end

	// queue memory write at base plus twice the negative offset, minus two
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			queue_wr_en <= 1'b0;
			queue_wr_addr <= 16'h0;
			queue_wr_data <= 16'h0;
		end else begin
			queue_wr_en <= push & ~wr_ptr;
			queue_wr_addr <= endpoint_table_base
				+ {{10{queue_write_pointer[4]}}, queue_write_pointer, 1'b0} - 16'h0002;
			queue_wr_data <= trn_ep_addr;
		end
	end

	// transaction complete flag; a new completion beats any clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			transaction_complete_flag <= 1'b0;
		end else if (trn_done & usb_enabled) begin
			transaction_complete_flag <= 1'b1;
		end else if (wr_ptr || (wr_flags && hwdata[B_F_TC])) begin
			transaction_complete_flag <= 1'b0;
		end else if (rp_read && q_dec(queue_read_pointer, highest_endpoint_number)
			== queue_write_pointer) begin
			transaction_complete_flag <= 1'b0;
		end
	end

	// bus reset detection from se0 time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			se0_cnt <= 9'h0;
			bus_reset_seen <= 1'b0;
		end else if (!line_se0 || !usb_enabled) begin
			se0_cnt <= 9'h0;
			bus_reset_seen <= 1'b0;
		end else if (se0_cnt != 9'(SE0_CYC - 1)) begin
			se0_cnt <= se0_cnt + 9'h001;
		end else begin
			bus_reset_seen <= 1'b1;
		end
	end

	// suspend, downstream resume and upstream resume drive
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_cnt <= 20'h0;
			drive_cnt <= 20'h0;
			suspended <= 1'b0;
			resume_drive <= 1'b0;
			resume_seen <= 1'b0;
			upstream_resume_flag <= 1'b0;
			remote_wake_request <= 1'b0;
		end else begin
			if (wr_line) begin
				remote_wake_request <= hwdata[B_WAKE];
			end
			if (!usb_enabled) begin
				idle_cnt <= 20'h0;
				suspended <= 1'b0;
				resume_drive <= 1'b0;
			end else if (resume_drive) begin
				// our own k state must not look like host resume
				if (drive_cnt == 20'(RESUME_N - 1)) begin
					resume_drive <= 1'b0;
					suspended <= 1'b0;
					idle_cnt <= 20'h0;
				end
				drive_cnt <= drive_cnt + 20'h00001;
			end else if (!line_idle) begin
				idle_cnt <= 20'h0;
				if (suspended) begin
					resume_seen <= 1'b1;
					suspended <= 1'b0;
				end
			end else begin
				if (idle_cnt != 20'(WAKE_N - 1)) begin
					idle_cnt <= idle_cnt + 20'h00001;
				end
				if (idle_cnt == 20'(SUSPEND_N - 1)) begin
					suspended <= 1'b1;
					resume_seen <= 1'b0;
					upstream_resume_flag <= 1'b0;
				end
				if (suspended && remote_wake_request && idle_cnt == 20'(WAKE_N - 1)) begin
					resume_drive <= 1'b1;
					drive_cnt <= 20'h0;
					upstream_resume_flag <= 1'b1;
					remote_wake_request <= 1'b0;
				end
			end
		end
	end

	// sticky bus event flags, write one to clear, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_start_flag <= 1'b0;
			bus_idle_flag <= 1'b0;
			wake_detect_flag <= 1'b0;
			bus_reset_flag <= 1'b0;
		end else begin
			frame_start_flag <= (sof_valid & usb_enabled)
				| (frame_start_flag & ~(wr_flags & hwdata[B_F_SOF]));
			bus_idle_flag <= (usb_enabled & line_idle & ~suspended & ~resume_drive
				& (idle_cnt == 20'(SUSPEND_N - 1)))
				| (bus_idle_flag & ~(wr_flags & hwdata[B_F_IDLE]));
			wake_detect_flag <= (usb_enabled & suspended & ~resume_drive & ~line_idle)
				| (wake_detect_flag & ~(wr_flags & hwdata[B_F_WAKE]));
			bus_reset_flag <= (usb_enabled & line_se0 & (se0_cnt == 9'(SE0_CYC - 1))
				& ~bus_reset_seen) | (bus_reset_flag & ~(wr_flags & hwdata[B_F_RST]));
		end
	end

	// interrupt request, gated by level field, the sof enable and one shared bus event enable
	assign bus_event_irq = (main_irq_level != 2'h0)
		& ((frame_start_irq_enable & frame_start_flag)
		| (bus_event_irq_enable & (bus_idle_flag | wake_detect_flag | bus_reset_flag)));

	sequence s_ptr_wr;
		a_valid & hwrite & a_map & ((a_idx == IDX_QWP) | (a_idx == IDX_QRP)) ##1 !trn_done;
	endsequence
	sequence s_ok_token;
		match & (pkt.ep <= highest_endpoint_number) & ~global_negative_ack;
	endsequence

	property p_flush;
		@(posedge hclk) disable iff (!hresetn)
		s_ptr_wr |=> (queue_write_pointer == 5'h0) && (queue_read_pointer == 5'h0)
			&& !transaction_complete_flag;
	endproperty
	a_flush: assert property (p_flush) else $error("pointer write did not flush");
	property p_fetch;
		@(posedge hclk) disable iff (!hresetn)
		s_ok_token |=> fetch.req && !pkt_nack && fetch.addr == $past(endpoint_table_base)
			+ {8'h0, $past(pkt.ep), 4'h0} + ($past(pkt.dir_in) ? 16'h0008 : 16'h0000);
	endproperty
	a_fetch: assert property (p_fetch) else $error("allowed token not fetched");
	property p_discard;
		@(posedge hclk) disable iff (!hresetn)
		pkt.valid && (pkt.ep > highest_endpoint_number || pkt.addr != dev_addr)
			|=> !fetch.req && !pkt_nack;
	endproperty
	a_discard: assert property (p_discard) else $error("foreign token answered");
	property p_global_negative_ack;
		@(posedge hclk) disable iff (!hresetn)
		allowed && global_negative_ack |=> pkt_nack && (fetch.req == $past(pkt.setup));
	endproperty
	a_global_negative_ack: assert property (p_global_negative_ack) else $error("global nack broken");
	property p_frame;
		@(posedge hclk) disable iff (!hresetn)
		sof_valid && usb_enabled && main_ctrl[B_FSTORE]
			|=> last_frame_number == $past(sof_frame);
	endproperty
	a_frame: assert property (p_frame) else $error("frame number not stored");
	property p_abort;
		@(posedge hclk) disable iff (!hresetn)
		$fell(usb_enabled) |=> transaction_abort ##1 !transaction_abort;
	endproperty
	a_abort: assert property (p_abort) else $error("no abort pulse");
	property p_bus_reset_seen;
		@(posedge hclk) disable iff (!hresetn)
		bus_reset_seen |-> $past(line_se0) && $past(line_se0, 8) && $past(usb_enabled);
	endproperty
	a_bus_reset_seen: assert property (p_bus_reset_seen) else $error("bus reset without se0");
	property p_pull;
		@(posedge hclk) disable iff (!hresetn)
		attach |-> (dp_pullup == full_speed) && (dm_pullup == !full_speed);
	endproperty
	a_pull: assert property (p_pull) else $error("wrong pull-up");
	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		bus_event_irq |-> main_irq_level != 2'h0
			&& ((frame_start_irq_enable && frame_start_flag) || bus_event_irq_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("ungated interrupt");
	property p_eptr;
		@(posedge hclk) disable iff (!hresetn)
		endpoint_table_base[0] == 1'b0;
	endproperty
	a_eptr: assert property (p_eptr) else $error("table base odd");
endmodule

// *** common/usb_ctrl_pkg.sv ***
/*
 usb_ctrl_pkg: register indices, field positions, reset values,
 timing constants and carrier structs of the usb device control block.
 assumes a 100 MHz hclk and 8-bit registers, one per 32-bit word.
*/
package usb_ctrl_pkg;
	// register indices, byte address is four times the index
	localparam logic [3:0] IDX_MAIN = 4'h0;
	localparam logic [3:0] IDX_LINE = 4'h1;
	localparam logic [3:0] IDX_STATE = 4'h2;
	localparam logic [3:0] IDX_ADDR = 4'h3;
	localparam logic [3:0] IDX_QWP = 4'h4;
	localparam logic [3:0] IDX_QRP = 4'h5;
	localparam logic [3:0] IDX_EPL = 4'h6;
	localparam logic [3:0] IDX_EPH = 4'h7;
	localparam logic [3:0] IDX_IRQEN = 4'h8;
	localparam logic [3:0] IDX_FRAME = 4'h9;
	localparam logic [3:0] IDX_FLAGS = 4'hA;
	// main control fields
	localparam int B_ENABLE = 7;
	localparam int B_SPEED = 6;
	localparam int B_QEN = 5;
	localparam int B_FSTORE = 4;
	// line control fields
	localparam int B_HOLD = 4;
	localparam int B_WAKE = 2;
	localparam int B_GLOBAL_NEGATIVE_ACK = 1;
	localparam int B_ATTACH = 0;
	// bus state fields
	localparam int B_URES = 3;
	localparam int B_RES = 2;
	localparam int B_SUSP = 1;
	localparam int B_BRST = 0;
	// interrupt enable and flag fields
	localparam int B_FRAME_START_IRQ_ENABLE = 7;
	localparam int B_BUS_EVENT_IRQ_ENABLE = 6;
	localparam int B_F_SOF = 7;
	localparam int B_F_IDLE = 6;
	localparam int B_F_WAKE = 5;
	localparam int B_F_RST = 4;
	localparam int B_F_TC = 1;
	// reset values and masks
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [15:0] EPTR_IMPL_MASK = 16'hFFFE;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SUSPEND_TIME_MS = 3;
	localparam int WAKE_TIME_MS = 5;
	localparam int RESUME_DRIVE_MS = 2;
	localparam int SE0_TIME_NS = 2500;
	localparam int NS_PER_MS = 1000000;
	localparam int SUSPEND_CYC = SUSPEND_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int WAKE_CYC = WAKE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int RESUME_CYC = RESUME_DRIVE_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int SE0_CYC = (SE0_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// incoming token from the serial engine
	typedef struct packed {
		logic valid; // one-cycle strobe
		logic [6:0] addr; // device address in token
		logic [3:0] ep; // endpoint number
		logic dir_in; // in direction
		logic setup; // setup token
	} pkt_t;
	// endpoint table fetch request
	typedef struct packed {
		logic req; // one-cycle strobe
		logic [15:0] addr; // entry byte address
	} fetch_t;
endpackage

// *** tb/usb_host_model.sv ***
/*
 usb_host_model: host and serial engine at the far side of the block.
 assumes the bench calls its tasks; every change follows a rising hclk.
*/
`timescale 1ns/1ps
module usb_host_model
	import usb_ctrl_pkg::*;
(
	input wire logic hclk, // system clock
	output pkt_t pkt, // token strobe
	output logic sof_valid, // sof strobe
	output logic [10:0] sof_frame, // frame number
	output logic trn_done, // completion strobe
	output logic [15:0] trn_ep_addr, // completed entry
	output logic line_idle, // idle level
	output logic line_se0 // se0 level
);
	// lines neither idle nor se0, strobes low
	initial begin
		pkt = '0;
		{sof_valid, sof_frame, trn_done, trn_ep_addr} = '0;
		{line_idle, line_se0} = 2'b00;
	end
	// one-cycle token, fields scrambled after so stale data never helps
	task automatic token(input logic [6:0] a, input logic [3:0] e, input logic i,
		input logic s);
		@(posedge hclk);
		pkt <= {1'b1, a, e, i, s};
		@(posedge hclk);
		pkt <= {1'b0, ~a, ~e, ~i, ~s};
	endtask
	// start of frame with its number
	task automatic sof(input logic [10:0] f);
		@(posedge hclk);
		{sof_valid, sof_frame} <= {1'b1, f};
		@(posedge hclk);
		{sof_valid, sof_frame} <= {1'b0, ~f};
	endtask
	// completed transaction with its table address
	task automatic done(input logic [15:0] a);
		@(posedge hclk);
		{trn_done, trn_ep_addr} <= {1'b1, a};
		@(posedge hclk);
		{trn_done, trn_ep_addr} <= {1'b0, ~a};
	endtask
	// hold a line state for n cycles
	task automatic line(input logic idle, input logic se0, input int n);
		@(posedge hclk);
		{line_idle, line_se0} <= {idle, se0};
		repeat (n) @(posedge hclk);
	endtask
endmodule

// *** tb/tb.sv ***
/*
 tb: self-checking bench of the usb device control block.
 assumes the host model on the far side and one ahb-lite master here.
*/
`timescale 1ns/1ps
module tb;
	import usb_ctrl_pkg::*;
	logic hclk = 1'b0; // system clock
	logic hresetn = 1'b0; // bus reset, active low
	logic por_n = 1'b0; // power-on reset, active low
	logic hsel = 1'b0; // slave select
	logic [31:0] haddr = 32'h0; // byte address
	logic [1:0] htrans = 2'b00; // transfer type
	logic hwrite = 1'b0; // write flag
	logic [2:0] hsize = 3'b010; // whole words only
	logic [31:0] hwdata = 32'h0; // write data
	logic [31:0] hrdata, rd; // read data
	logic hreadyout, hresp, pkt_nack, usb_enabled, full_speed, dp_pullup, dm_pullup;
	logic sof_valid, trn_done, line_idle, line_se0, queue_wr_en, bus_event_irq;
	logic transaction_complete_flag; // queue pending
	logic [10:0] sof_frame; // frame number
	logic [15:0] trn_ep_addr, queue_wr_addr, queue_wr_data, base, x;
	logic [6:0] ea; // our device address
	logic [1:0] lvl; // interrupt level seen
	logic [10:0] f; // random frame
	logic [7:0] m; // random main control
	pkt_t pkt; // token
	fetch_t fetch; // table fetch
	int err_count = 0, n_checks = 0, cyc = 0;
	always #5 hclk = ~hclk;
	usb_host_model u_host (.hclk(hclk), .pkt(pkt), .sof_valid(sof_valid),
		.sof_frame(sof_frame), .trn_done(trn_done), .trn_ep_addr(trn_ep_addr),
		.line_idle(line_idle), .line_se0(line_se0));
	// short counts keep the line timers within a few hundred cycles
	usb_device_control_regs #(.SUSPEND_N(20), .WAKE_N(40), .RESUME_N(10)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pkt(pkt), .sof_valid(sof_valid), .sof_frame(sof_frame), .trn_done(trn_done),
		.trn_ep_addr(trn_ep_addr), .line_idle(line_idle), .line_se0(line_se0),
		.fetch(fetch), .pkt_nack(pkt_nack), .usb_enabled(usb_enabled),
		.full_speed(full_speed), .transaction_abort(), .dp_pullup(dp_pullup),
		.dm_pullup(dm_pullup), .resume_drive(), .queue_wr_en(queue_wr_en),
		.queue_wr_addr(queue_wr_addr), .queue_wr_data(queue_wr_data),
		.transaction_complete_flag(transaction_complete_flag),
		.irq_priority_level(lvl), .bus_event_irq(bus_event_irq));
	// verdict and end of run
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard, run needs under a thousand cycles
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	// the one compare, four-state exact
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// single ahb-lite transfer, held until hready is seen high
	task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 26'h0, i, 2'b00};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
		@(posedge hclk); // write lands at the data edge, check after it
	endtask
	task automatic rdchk(input logic [3:0] i, input logic [31:0] e);
		bus(1'b0, i, 8'h00);
		chk("register", e, rd);
	endtask
	// entry byte address of an endpoint in the table
	function automatic logic [15:0] fexp(logic [15:0] b, logic [3:0] e, logic din);
		return b + 16'(e) * 16'h0010 + (din ? 16'h0008 : 16'h0000);
	endfunction
	// writes with reserved, read-only or flushing bits, and what reads back
	logic [3:0] ti [7] = '{IDX_LINE, IDX_ADDR, IDX_EPL, IDX_EPH, IDX_IRQEN, IDX_QWP, IDX_STATE};
	logic [7:0] tw [7] = '{8'hFB, 8'hFF, 8'hFF, 8'hA5, 8'hFF, 8'h1F, 8'hFF};
	logic [7:0] te [7] = '{8'h13, 8'h7F, 8'hFE, 8'hA5, 8'hC3, 8'h00, 8'h00};
	initial begin
		void'($urandom(66));
		repeat (16) @(posedge hclk);
		{hresetn, por_n} <= 2'b11;
		for (int k = 0; k < 12; k++) rdchk(4'(k), 32'h0);
		for (int k = 0; k < 7; k++) begin
			wr(ti[k], tw[k]);
			rdchk(ti[k], {24'h0, te[k]});
		end
		m = 8'($urandom);
		wr(IDX_MAIN, m);
		rdchk(IDX_MAIN, {24'h0, m});
		chk("enable", {31'h0, m[7]}, {31'h0, usb_enabled});
		chk("speed", {31'h0, m[6]}, {31'h0, full_speed});
		// tokens: limit, address match, global nack
		ea = 7'($urandom);
		base = 16'($urandom) & 16'hFFFE;
		wr(IDX_LINE, 8'h00);
		wr(IDX_ADDR, {1'b0, ea});
		wr(IDX_EPL, base[7:0]);
		wr(IDX_EPH, base[15:8]);
		wr(IDX_MAIN, 8'h83);
		for (int k = 0; k < 8; k++) begin
			x[0] = 1'($urandom);
			u_host.token(ea, 4'(k), x[0], 1'b0);
			#1;
			chk("fetch_req", {31'h0, k <= 3}, {31'h0, fetch.req});
			if (k <= 3) chk("fetch_addr", 32'(fexp(base, 4'(k), x[0])), 32'(fetch.addr));
		end
		u_host.token(ea ^ 7'h01, 4'h0, 1'b0, 1'b0);
		#1;
		chk("foreign", 32'h0, {31'h0, fetch.req});
		wr(IDX_MAIN, 8'h03);
		u_host.token(ea, 4'h0, 1'b0, 1'b0);
		#1;
		chk("off", 32'h0, {31'h0, fetch.req});
		wr(IDX_MAIN, 8'h83);
		wr(IDX_LINE, 8'h02);
		u_host.token(ea, 4'h1, 1'b0, 1'b0);
		#1;
		chk("nack", 32'h2, {30'h0, pkt_nack, fetch.req});
		u_host.token(ea, 4'h1, 1'b0, 1'b1);
		#1;
		chk("setup", 32'h3, {30'h0, pkt_nack, fetch.req});
		// completion queue
		wr(IDX_LINE, 8'h00);
		wr(IDX_MAIN, 8'hA3);
		x = 16'($urandom);
		u_host.done(x);
		#1;
		chk("qwr", {16'h1, base - 16'h2}, {15'h0, queue_wr_en, queue_wr_addr});
		chk("qdata", {16'h0, x}, {16'h0, queue_wr_data});
		rdchk(IDX_QWP, 32'h1F);
		chk("tcflag", 32'h1, {31'h0, transaction_complete_flag});
		rdchk(IDX_QRP, 32'h0);
		chk("tcflag", 32'h0, {31'h0, transaction_complete_flag});
		u_host.done(x);
		wr(IDX_QRP, 8'h00);
		chk("tcflag", 32'h0, {31'h0, transaction_complete_flag});
		rdchk(IDX_QWP, 32'h0);
		wr(IDX_MAIN, 8'hA0);
		repeat (2) u_host.done(x);
		rdchk(IDX_QWP, 32'h0);
		// frame number store on and off
		f = 11'($urandom);
		wr(IDX_MAIN, 8'h90);
		u_host.sof(f);
		rdchk(IDX_FRAME, {24'h0, f[7:0]});
		wr(IDX_MAIN, 8'h80);
		u_host.sof(~f);
		rdchk(IDX_FRAME, {24'h0, f[7:0]});
		// line events and bus event request
		u_host.line(1'b0, 1'b1, 260);
		bus(1'b0, IDX_STATE, 8'h00);
		chk("bus_reset_seen", 32'h1, rd & 32'h1);
		wr(IDX_IRQEN, 8'h41);
		chk("level", 32'h1, {30'h0, lvl});
		u_host.line(1'b1, 1'b0, 30);
		bus(1'b0, IDX_STATE, 8'h00);
		chk("suspend", 32'h2, rd & 32'h2);
		chk("bus_irq", 32'h1, {31'h0, bus_event_irq});
		wr(IDX_IRQEN, 8'h40);
		chk("bus_irq", 32'h0, {31'h0, bus_event_irq});
		u_host.line(1'b0, 1'b0, 5);
		bus(1'b0, IDX_STATE, 8'h00);
		chk("resume", 32'h4, rd & 32'h4);
		rdchk(IDX_FLAGS, 32'hF2);
		wr(IDX_FLAGS, 8'hF2);
		rdchk(IDX_FLAGS, 32'h0);
		wr(IDX_LINE, 8'h04);
		u_host.line(1'b1, 1'b0, 55);
		bus(1'b0, IDX_STATE, 8'h00);
		chk("upstream_resume_flag", 32'h8, rd & 32'h8);
		// pull-ups by speed, then held through reset
		wr(IDX_MAIN, 8'hC0);
		wr(IDX_LINE, 8'h01);
		chk("pull_fs", 32'h2, {30'h0, dp_pullup, dm_pullup});
		wr(IDX_MAIN, 8'h80);
		chk("pull_ls", 32'h1, {30'h0, dp_pullup, dm_pullup});
		wr(IDX_LINE, 8'h11);
		@(posedge hclk) hresetn <= 1'b0;
		@(posedge hclk) #1;
		chk("pull_rst", 32'h1, {30'h0, dp_pullup, dm_pullup});
		@(posedge hclk) hresetn <= 1'b1;
		rdchk(IDX_LINE, 32'h10);
		@(posedge hclk) por_n <= 1'b0;
		@(posedge hclk) por_n <= 1'b1;
		rdchk(IDX_LINE, 32'h0);
		wrap_up();
	end
endmodule
